/* sleep_ctrl_defines.svh */
`ifndef SLEEP_CTRL_DEFINES_SVH
`define SLEEP_CTRL_DEFINES_SVH

// register byte offsets
`define OFS_PWR_CTRL 8'h00
`define OFS_INT_CTRL 8'h04
`define OFS_STATE 8'h08
`define OFS_EV_STATUS 8'h0C
`define OFS_EV_MASK 8'h10

// field positions
`define BIT_STANDBY_SEL 0
`define BIT_NMI_EDGE 0
`define BIT_ST_SLEEP 0
`define BIT_ST_POR 1
`define BIT_ST_MANUAL 2
`define BIT_ST_NMI_PIN 3
`define EV_ENTER 0
`define EV_IRQ 1
`define EV_DMA 2
`define EV_NMI 3
`define EV_RESET 4

// widths and reset values
`define EV_W 5
`define IRQ_LEVEL_W 4
`define RST_STANDBY_SEL 1'h0
`define RST_NMI_EDGE 1'h0
`define RST_EV 5'h00

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* sleep_ctrl_pkg.sv */
`include "sleep_ctrl_defines.svh"

package sleep_ctrl_pkg;

    // cpu run state
    typedef enum logic [0:0] {RUN, SLEEP} state_e;

    // interrupt request offered by the interrupt controller
    typedef struct packed {
        logic valid;                             // a request is pending
        logic source_enabled;                    // enabled inside its peripheral
        logic [`IRQ_LEVEL_W-1:0] level;          // priority level
    } irq_req_s;

    // one-cycle wake cause report
    typedef struct packed {
        logic by_reset;
        logic by_nmi;
        logic by_dma;
        logic by_irq;
    } wake_s;

    // sticky event bits
    typedef logic [`EV_W-1:0] ev_t;

endpackage : sleep_ctrl_pkg

/* pin_sync.sv */
`timescale 1ns/100ps

// two-stage synchroniser for asynchronous pins
module pin_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pins and synchronised levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] meta_reg; // first stage, read only by second

    // both stages in one process, first one feeds only the second
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            meta_reg <= RESET_VAL;
            level <= RESET_VAL;
        end
        else
        begin
            meta_reg <= pin;
            level <= meta_reg;
        end
    end

endmodule : pin_sync

/* edge_detect.sv */
`timescale 1ns/100ps

// rise and fall pulses of an already synchronised level
module edge_detect
#(
    parameter logic IDLE = 1'h0
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // level in, pulses out
    input wire logic level,
    output logic rise,
    output logic fall
);

    logic prev_reg; // level one cycle ago

    // idle value at reset avoids a false edge after release
    always_ff @(posedge mclk)
    begin
        if (reset)
            prev_reg <= IDLE;
        else
            prev_reg <= level;
    end

    // edges are combinational on the synchronised level
    assign rise = level && !prev_reg;
    assign fall = !level && prev_reg;

endmodule : edge_detect

/* sleep_mode_control.sv */
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "sleep_ctrl_defines.svh"

// Summary of operation
// - sleep instruction with standby clear enters sleep
// - core halts after sleep, registers kept
// - peripherals and dma keep running in sleep
// - only four events end sleep
// - accepted interrupt wakes and starts exception handling
// - interrupt at or below mask level cannot wake
// - peripheral-disabled interrupt cannot wake
// - dma address error during sleep wakes
// - reset pin low, nmi high gives power-on reset
// - reset pin low, nmi low gives manual reset
// - selected rising nmi edge raises nmi, wakes
// - selected falling nmi edge raises nmi, wakes
module sleep_mode_control
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu core and interrupt controller
    input wire logic sleep_exec,
    input wire logic [`IRQ_LEVEL_W-1:0] cpu_status_word_mask,
    input wire sleep_ctrl_pkg::irq_req_s irq_req,
    input wire logic dma_addr_err,
    // external pins
    input wire logic external_init_pin_n,
    input wire logic nmi_pin,
    // clock gates and reset requests
    output logic core_clk_en,
    output logic periph_clk_en,
    output logic sleeping,
    output sleep_ctrl_pkg::wake_s wake_cause,
    output logic nmi_req,
    output logic por_state,
    output logic manual_state,
    // interrupt
    output logic irq_out
);

    sleep_ctrl_pkg::state_e state_reg; // run or sleep
    logic standby_select_bit_reg; // power_down_control_register field
    logic nonmaskable_edge_select_reg; // 1 rising, 0 falling
    sleep_ctrl_pkg::ev_t ev_status_reg; // sticky events
    sleep_ctrl_pkg::ev_t ev_mask_reg; // interrupt mask
    sleep_ctrl_pkg::ev_t ev_set; // events this cycle
    sleep_ctrl_pkg::ev_t ev_clr; // write-one-to-clear
    logic init_n_s; // synchronised reset pin
    logic nmi_s; // synchronised nmi pin
    logic init_rise;
    logic init_fall;
    logic nmi_rise;
    logic nmi_fall;
    logic irq_accept; // interrupt that may wake
    logic nmi_event; // selected nmi edge
    logic wake_any; // any of the four exit causes
    logic enter_sleep;
    logic leave_sleep;
    logic [7:0] awaddr_reg;
    logic [7:0] araddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write; // address and data both held
    logic wr_mapped;
    logic rd_mapped;
    logic [31:0] rd_word;

    // pins come from outside the clock domain
    pin_sync #(.WIDTH(2), .RESET_VAL(2'h2)) u_pin_sync
    (
        .mclk(mclk),
        .reset(reset),
        .pin({external_init_pin_n, nmi_pin}),
        .level({init_n_s, nmi_s})
    );

    // reset pin idles high
    edge_detect #(.IDLE(1'h1)) u_init_edge
    (
        .mclk(mclk),
        .reset(reset),
        .level(init_n_s),
        .rise(init_rise),
        .fall(init_fall)
    );

    // nmi pin idles low
    edge_detect #(.IDLE(1'h0)) u_nmi_edge
    (
        .mclk(mclk),
        .reset(reset),
        .level(nmi_s),
        .rise(nmi_rise),
        .fall(nmi_fall)
    );

    // wake qualification
    always_comb
    begin
        irq_accept = irq_req.valid && irq_req.source_enabled
            && (irq_req.level > cpu_status_word_mask);
        nmi_event = nonmaskable_edge_select_reg ? nmi_rise : nmi_fall;
        wake_any = irq_accept || dma_addr_err || nmi_event || init_fall;
        // a reset edge in the same cycle outranks the sleep instruction
        enter_sleep = (state_reg == sleep_ctrl_pkg::RUN) && sleep_exec
            && !standby_select_bit_reg && !init_fall;
        leave_sleep = (state_reg == sleep_ctrl_pkg::SLEEP) && wake_any;
    end

    // run/sleep state
    always_ff @(posedge mclk)
    begin
        if (reset)
            state_reg <= sleep_ctrl_pkg::RUN;
        else
            unique case (state_reg)
                sleep_ctrl_pkg::RUN:
                    if (enter_sleep)
                        state_reg <= sleep_ctrl_pkg::SLEEP;
                sleep_ctrl_pkg::SLEEP:
                    if (wake_any)
                        state_reg <= sleep_ctrl_pkg::RUN;
            endcase
    end

    // core clock gate; core registers hold because only its clock stops
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            core_clk_en <= 1'h1;
            sleeping <= 1'h0;
        end
        else if (enter_sleep)
        begin
            core_clk_en <= 1'h0;
            sleeping <= 1'h1;
        end
        else if (leave_sleep)
        begin
            core_clk_en <= 1'h1;
            sleeping <= 1'h0;
        end
    end

    // peripheral and dma clocks are never gated by sleep
    always_ff @(posedge mclk)
    begin
        if (reset)
            periph_clk_en <= 1'h1;
        else
            periph_clk_en <= 1'h1;
    end

    // one-cycle wake cause report toward exception handling
    always_ff @(posedge mclk)
    begin
        if (reset)
            wake_cause <= '0;
        else
        begin
            wake_cause.by_irq <= leave_sleep && irq_accept;
            wake_cause.by_dma <= leave_sleep && dma_addr_err;
            wake_cause.by_nmi <= leave_sleep && nmi_event;
            wake_cause.by_reset <= leave_sleep && init_fall;
        end
    end

    // nmi is raised on the selected edge in any state
    always_ff @(posedge mclk)
    begin
        if (reset)
            nmi_req <= 1'h0;
        else
            nmi_req <= nmi_event;
    end

    // reset kind is taken from the nmi level at the reset pin's fall;
    // relies on the outside settling nmi first
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            por_state <= 1'h0;
            manual_state <= 1'h0;
        end
        else if (init_fall)
        begin
            por_state <= nmi_s;
            manual_state <= !nmi_s;
        end
        else if (init_rise)
        begin
            por_state <= 1'h0;
            manual_state <= 1'h0;
        end
    end

    // sticky events, set wins over clear
    always_comb
    begin
        ev_set = '0;
        ev_set[`EV_ENTER] = enter_sleep;
        ev_set[`EV_IRQ] = leave_sleep && irq_accept;
        ev_set[`EV_DMA] = leave_sleep && dma_addr_err;
        ev_set[`EV_NMI] = leave_sleep && nmi_event;
        ev_set[`EV_RESET] = leave_sleep && init_fall;
        ev_clr = '0;
        if (do_write && wstrb_reg[0] && (awaddr_reg == `OFS_EV_STATUS))
            ev_clr = wdata_reg[`EV_W-1:0];
    end

    // event status register
    always_ff @(posedge mclk)
    begin
        if (reset)
            ev_status_reg <= `RST_EV;
        else
            ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
    end

    // level interrupt from unmasked status
    always_ff @(posedge mclk)
    begin
        if (reset)
            irq_out <= 1'h0;
        else
            irq_out <= |(ev_status_reg & ev_mask_reg);
    end

    // software-written control bits
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            standby_select_bit_reg <= `RST_STANDBY_SEL;
            nonmaskable_edge_select_reg <= `RST_NMI_EDGE;
            ev_mask_reg <= `RST_EV;
        end
        else if (do_write && wstrb_reg[0])
        begin
            unique case (awaddr_reg)
                `OFS_PWR_CTRL:
                    standby_select_bit_reg <= wdata_reg[`BIT_STANDBY_SEL];
                `OFS_INT_CTRL:
                    nonmaskable_edge_select_reg <= wdata_reg[`BIT_NMI_EDGE];
                `OFS_EV_MASK:
                    ev_mask_reg <= wdata_reg[`EV_W-1:0];
                default:
                    ; // status, state and unmapped: no store
            endcase
        end
    end

    // write channels: address and data taken in either order
    always_comb
    begin
        do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
        wr_mapped = (awaddr_reg == `OFS_PWR_CTRL) || (awaddr_reg == `OFS_INT_CTRL)
            || (awaddr_reg == `OFS_STATE) || (awaddr_reg == `OFS_EV_STATUS)
            || (awaddr_reg == `OFS_EV_MASK);
    end

    // write handshake; ready drops once an item is held
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'h1;
            s_axi_wready <= 1'h1;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= `RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'h0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'h1;
                s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'h0;
                s_axi_awready <= 1'h1;
                s_axi_wready <= 1'h1;
            end
        end
    end

    // read data mux; unused bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_mapped = 1'h1;
        unique case (araddr_reg)
            `OFS_PWR_CTRL: rd_word[`BIT_STANDBY_SEL] = standby_select_bit_reg;
            `OFS_INT_CTRL: rd_word[`BIT_NMI_EDGE] = nonmaskable_edge_select_reg;
            `OFS_STATE:
            begin
                rd_word[`BIT_ST_SLEEP] = sleeping;
                rd_word[`BIT_ST_POR] = por_state;
                rd_word[`BIT_ST_MANUAL] = manual_state;
                rd_word[`BIT_ST_NMI_PIN] = nmi_s;
            end
            `OFS_EV_STATUS: rd_word[`EV_W-1:0] = ev_status_reg;
            `OFS_EV_MASK: rd_word[`EV_W-1:0] = ev_mask_reg;
            default: rd_mapped = 1'h0;
        endcase
    end

    // read handshake: address, then data one cycle later
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
            araddr_reg <= 8'h00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            araddr_reg <= s_axi_araddr;
            s_axi_arready <= 1'h0;
        end
        else if (!s_axi_arready && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'h0;
            s_axi_arready <= 1'h1;
        end
    end

    // checks
    sequence s_enter;
        (state_reg == sleep_ctrl_pkg::RUN) && sleep_exec && !standby_select_bit_reg
            && !init_fall;
    endsequence

    sequence s_asleep_quiet;
        sleeping && !dma_addr_err && !nmi_event && !init_fall;
    endsequence

    a_sleep_entry: assert property (@(posedge mclk) disable iff (reset)
        s_enter |=> sleeping && !core_clk_en)
        else $error("sleep not entered");

    a_core_held: assert property (@(posedge mclk) disable iff (reset)
        sleeping |-> !core_clk_en)
        else $error("core clock running in sleep");

    a_periph_run: assert property (@(posedge mclk) disable iff (reset)
        s_enter |=> periph_clk_en [*3])
        else $error("peripheral clock stopped");

    a_no_wake: assert property (@(posedge mclk) disable iff (reset)
        sleeping && !wake_any |=> sleeping)
        else $error("sleep left without cause");

    a_irq_wake: assert property (@(posedge mclk) disable iff (reset)
        s_asleep_quiet ##0 irq_accept |=> !sleeping && core_clk_en && wake_cause.by_irq)
        else $error("accepted interrupt did not wake");

    a_mask_hold: assert property (@(posedge mclk) disable iff (reset)
        s_asleep_quiet ##0 (irq_req.level <= cpu_status_word_mask) |=> sleeping)
        else $error("masked interrupt woke");

    a_disabled_hold: assert property (@(posedge mclk) disable iff (reset)
        s_asleep_quiet ##0 !irq_req.source_enabled |=> sleeping)
        else $error("disabled interrupt woke");

    a_dma_wake: assert property (@(posedge mclk) disable iff (reset)
        sleeping && dma_addr_err |=> !sleeping && wake_cause.by_dma)
        else $error("dma error did not wake");

    a_por_select: assert property (@(posedge mclk) disable iff (reset)
        init_fall && nmi_s |=> por_state && !manual_state && !sleeping)
        else $error("power-on reset not entered");

    a_manual_select: assert property (@(posedge mclk) disable iff (reset)
        init_fall && !nmi_s |=> manual_state && !por_state && !sleeping)
        else $error("manual reset not entered");

    a_nmi_rise: assert property (@(posedge mclk) disable iff (reset)
        nonmaskable_edge_select_reg && $rose(nmi_s) |=> nmi_req)
        else $error("rising nmi not raised");

    a_nmi_fall: assert property (@(posedge mclk) disable iff (reset)
        sleeping && !nonmaskable_edge_select_reg && $fell(nmi_s) |=> nmi_req && !sleeping)
        else $error("falling nmi did not wake");

    a_clk_restore: assert property (@(posedge mclk) disable iff (reset)
        sleeping && wake_any |=> core_clk_en && periph_clk_en)
        else $error("core clock not restored");

endmodule : sleep_mode_control

/* sleep_partner.sv */
`timescale 1ns/100ps
`include "sleep_ctrl_defines.svh"

// cpu core, interrupt controller and external pin driver
module sleep_partner
(
    // clock
    input wire logic mclk,
    // core clock gate seen by the cpu
    input wire logic core_clk_en,
    // cpu and interrupt controller
    output logic sleep_exec,
    output logic [`IRQ_LEVEL_W-1:0] cpu_status_word_mask,
    output sleep_ctrl_pkg::irq_req_s irq_req,
    output logic dma_addr_err,
    // external pins
    output logic external_init_pin_n,
    output logic nmi_pin
);
    // idle levels at time zero
    initial
    begin
        sleep_exec = 1'h0;
        cpu_status_word_mask = '0;
        irq_req = '0;
        dma_addr_err = 1'h0;
        external_init_pin_n = 1'h1;
        nmi_pin = 1'h0;
    end

    // a gated core cannot issue another sleep instruction
    task automatic do_sleep();
        @(posedge mclk);
        if (core_clk_en === 1'h1)
            sleep_exec <= 1'h1;
        @(posedge mclk);
        sleep_exec <= 1'h0;
    endtask : do_sleep

    // request and mask change together, released level carries junk
    task automatic set_irq(input logic v, input logic en, input logic [3:0] lvl,
        input logic [3:0] m);
        @(posedge mclk);
        irq_req.valid <= v;
        irq_req.source_enabled <= en;
        irq_req.level <= v ? lvl : 4'($urandom);
        cpu_status_word_mask <= m;
    endtask : set_irq

    // one-cycle address error report
    task automatic dma_pulse();
        @(posedge mclk);
        dma_addr_err <= 1'h1;
        @(posedge mclk);
        dma_addr_err <= 1'h0;
    endtask : dma_pulse

    // nmi pin level
    task automatic set_nmi(input logic v);
        @(posedge mclk);
        nmi_pin <= v;
    endtask : set_nmi

    // nmi settles well before the reset pin drops
    task automatic reset_pin(input logic kind);
        @(posedge mclk);
        nmi_pin <= kind;
        repeat (4) @(posedge mclk);
        external_init_pin_n <= 1'h0;
    endtask : reset_pin

    // reset pin back high
    task automatic release_pin();
        @(posedge mclk);
        external_init_pin_n <= 1'h1;
    endtask : release_pin
endmodule : sleep_partner

/* tb_sleep_mode_control.sv */
`timescale 1ns/100ps
`include "sleep_ctrl_defines.svh"

// bench for the sleep controller
module tb_sleep_mode_control;
    // design signals
    logic mclk, reset;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic sleep_exec, dma_addr_err, external_init_pin_n, nmi_pin;
    logic [`IRQ_LEVEL_W-1:0] cpu_status_word_mask;
    sleep_ctrl_pkg::irq_req_s irq_req;
    sleep_ctrl_pkg::wake_s wake_cause;
    logic core_clk_en, periph_clk_en, sleeping, nmi_req, por_state, manual_state, irq_out;
    // bench model state
    int fails, samples_checked, exp_status;
    logic nmi_seen;
    logic [3:0] lvl, m;
    logic en;

    sleep_mode_control sleep_mode_control_i
    (
        .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .cpu_status_word_mask,
        .irq_req, .dma_addr_err, .external_init_pin_n, .nmi_pin, .core_clk_en,
        .periph_clk_en, .sleeping, .wake_cause, .nmi_req, .por_state, .manual_state, .irq_out
    );

    sleep_partner sleep_partner_i
    (
        .mclk, .core_clk_en, .sleep_exec, .cpu_status_word_mask, .irq_req, .dma_addr_err,
        .external_init_pin_n, .nmi_pin
    );

    // 125 MHz clock
    initial
    begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // idle cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        int n;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'h1;
        while (!(aw_ok && w_ok) && n < 50)
        begin
            @(posedge mclk);
            n++;
            if (!aw_ok && s_axi_awready === 1'h1)
            begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_ok && s_axi_wready === 1'h1)
            begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
        end while (s_axi_bvalid !== 1'h1 && n < 100);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er, "write response");
    endtask : axi_wr

    // read and compare data and response
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
        end while (s_axi_arready !== 1'h1 && n < 50);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            n++;
        end while (s_axi_rvalid !== 1'h1 && n < 100);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, exp, "read data");
        chk(s_axi_rresp, er, "read response");
    endtask : axi_rd

    // sleep instruction with standby clear
    task automatic enter_sleep();
        sleep_partner_i.do_sleep();
        #1;
        chk(sleeping, 1'h1, "sleep entry");
        chk(core_clk_en, 1'h0, "core clock gated");
        chk(periph_clk_en, 1'h1, "peripherals run");
        exp_status |= 1;
    endtask : enter_sleep

    // bounded wait for the exit, then the cause pulse
    task automatic wait_wake(input logic [3:0] cause);
        int n;
        n = 0;
        nmi_seen = 1'h0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
            if (nmi_req === 1'h1)
                nmi_seen = 1'h1;
        end while (sleeping !== 1'h0 && n < 12);
        chk(wake_cause, cause, "wake cause");
        chk(core_clk_en, 1'h1, "core clock back");
    endtask : wait_wake

    // hang guard, far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run();
    end

    // main sequence
    initial
    begin
        reset = 1'h1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        fails = 0;
        samples_checked = 0;
        exp_status = 0;
        void'($urandom(32'h299ea31e));
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        #1;
        chk({core_clk_en, periph_clk_en, sleeping, irq_out, por_state, manual_state}, 6'h30,
            "outputs after reset");
        // register defaults, read-only and unmapped places
        for (int i = 0; i < 5; i++)
            axi_rd(8'(4 * i), 32'h0, `RESP_OKAY);
        axi_rd(8'h14, 32'h0, `RESP_SLVERR);
        axi_wr(8'h14, 32'hFF, `RESP_SLVERR);
        axi_wr(`OFS_STATE, 32'hF, `RESP_OKAY);
        axi_rd(`OFS_STATE, 32'h0, `RESP_OKAY);
        // standby selected: sleep instruction must not gate the core
        axi_wr(`OFS_PWR_CTRL, 32'h1, `RESP_OKAY);
        axi_rd(`OFS_PWR_CTRL, 32'h1, `RESP_OKAY);
        sleep_partner_i.do_sleep();
        #1;
        chk(sleeping, 1'h0, "standby blocks sleep");
        axi_wr(`OFS_PWR_CTRL, 32'h0, `RESP_OKAY);
        // interrupt trials: accepted, equal to mask, disabled, then random
        for (int t = 0; t < 8; t++)
        begin
            lvl = (t == 0) ? 4'h5 : (t == 1) ? 4'h7 : 4'($urandom);
            m = (t == 0) ? 4'h3 : (t == 1) ? 4'h7 : 4'($urandom);
            en = (t == 2) ? 1'h0 : (t < 2) ? 1'h1 : 1'($urandom);
            enter_sleep();
            sleep_partner_i.set_irq(1'h1, en, lvl, m);
            if (en && int'(lvl) > int'(m))
            begin
                wait_wake(4'h1);
                exp_status |= 2;
            end
            else
            begin
                cyc(6);
                #1;
                chk(sleeping, 1'h1, "refused irq keeps sleep");
                sleep_partner_i.set_irq(1'h0, 1'h0, 4'h0, m);
                fork
                    sleep_partner_i.dma_pulse();
                join_none
                wait_wake(4'h2);
                exp_status |= 4;
            end
            sleep_partner_i.set_irq(1'h0, 1'h0, 4'h0, 4'h0);
        end
        // rising nmi edge selected
        axi_wr(`OFS_INT_CTRL, 32'h1, `RESP_OKAY);
        axi_rd(`OFS_INT_CTRL, 32'h1, `RESP_OKAY);
        enter_sleep();
        sleep_partner_i.set_nmi(1'h1);
        wait_wake(4'h4);
        chk(nmi_seen, 1'h1, "nmi on rise");
        // reset pin with nmi high
        enter_sleep();
        sleep_partner_i.reset_pin(1'h1);
        wait_wake(4'h8);
        cyc(2);
        #1;
        chk({por_state, manual_state}, 2'h2, "power-on kind");
        sleep_partner_i.release_pin();
        cyc(6);
        #1;
        chk(por_state, 1'h0, "power-on state ends");
        // falling nmi edge selected
        axi_wr(`OFS_INT_CTRL, 32'h0, `RESP_OKAY);
        enter_sleep();
        sleep_partner_i.set_nmi(1'h0);
        wait_wake(4'h4);
        chk(nmi_seen, 1'h1, "nmi on fall");
        // reset pin with nmi low
        enter_sleep();
        sleep_partner_i.reset_pin(1'h0);
        wait_wake(4'h8);
        cyc(2);
        #1;
        chk({por_state, manual_state}, 2'h1, "manual kind");
        sleep_partner_i.release_pin();
        cyc(6);
        exp_status |= 8 | 16;
        // sticky events, mask and interrupt output
        axi_rd(`OFS_EV_STATUS, exp_status, `RESP_OKAY);
        chk(irq_out, 1'h0, "all masked");
        axi_wr(`OFS_EV_MASK, 32'h2, `RESP_OKAY);
        cyc(2);
        #1;
        chk(irq_out, 1'h1, "unmasked event");
        axi_wr(`OFS_EV_STATUS, 32'h2, `RESP_OKAY);
        cyc(2);
        #1;
        chk(irq_out, 1'h0, "event cleared");
        axi_rd(`OFS_EV_STATUS, exp_status & ~2, `RESP_OKAY);
        complete_run();
    end
endmodule : tb_sleep_mode_control
